// ---- design/serial_config_pkg.sv ----
`default_nettype none
package serial_config_pkg;
  // register indices (six-bit address space)
  localparam logic [5:0] addr_power_down_control = 6'h01;
  localparam logic [5:0] addr_amplifier_bias_trim = 6'h02;
  localparam logic [5:0] addr_converter_bias_trim = 6'h03;
  localparam int addr_width = 6;
  localparam int data_width = 8;
  localparam int reg_count = 64;
  localparam int frame_bits = 16;
  localparam int out_bits = 8;
  // command field positions within the 16-bit frame
  localparam int pos_direction = 15;
  localparam int pos_device = 14;
  localparam int pos_addr_hi = 13;
  localparam int pos_addr_lo = 8;
  localparam logic device_address = 1'b0;
  localparam logic dir_write = 1'b0;
  // power down control field positions
  localparam int pd_master = 7;
  localparam int pd_clamp = 6;
  localparam int pd_ch2_refbuf = 5;
  localparam int pd_ch1_refbuf = 4;
  localparam int pd_ch2_amp = 3;
  localparam int pd_ch1_amp = 2;
  localparam int pd_ch2_conv = 1;
  localparam int pd_ch1_conv = 0;
  // trim field positions
  localparam int trim_stage1_lo = 0;
  localparam int trim_stage2_lo = 3;
  localparam int trim_field_width = 3;
  // values before the baseline write
  localparam logic [7:0] reset_value = 8'h00;
  // pin synchroniser depth
  localparam int sync_stages = 3;
endpackage
`default_nettype wire

// ---- design/config_reg_mem.sv ----
`default_nettype none
module config_reg_mem #(
  parameter int addr_width = 6,
  parameter int data_width = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // write port
  input wire logic wr_en,
  input wire logic [addr_width-1:0] wr_addr,
  input wire logic [data_width-1:0] wr_data,
  // read port, data registered
  input wire logic rd_en,
  input wire logic [addr_width-1:0] rd_addr,
  output logic [data_width-1:0] rd_data
);
  if (addr_width < 1 || data_width < 1) begin : bad_size
    $error("config_reg_mem: addr_width and data_width must be positive");
  end

  logic [data_width-1:0] mem [0:(1<<addr_width)-1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < (1<<addr_width); i++) begin
        mem[i] <= '0;
      end
    end else if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (clk_en && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ---- design/serial_config_port.sv ----
`default_nettype none
module serial_config_port #(
  parameter int addr_width = serial_config_pkg::addr_width,
  parameter int data_width = serial_config_pkg::data_width
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // serial port pins
  input wire logic shift_clock,
  input wire logic select_active_low,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  // power down controls per block
  output logic clamp_voltage_source_pd,
  output logic ch1_refbuf_pd,
  output logic ch2_refbuf_pd,
  output logic ch1_gain_amplifier_pd,
  output logic ch2_gain_amplifier_pd,
  output logic ch1_converter_pd,
  output logic ch2_converter_pd,
  // bias trims shared by both channels
  output logic [2:0] amp_stage1_trim,
  output logic [2:0] amp_stage2_trim,
  output logic [2:0] conv_level1_trim,
  output logic [2:0] conv_level2_trim
);
  // the frame layout and the pin filter are fixed, so refuse sizes they cannot serve
  if (addr_width != serial_config_pkg::addr_width) begin : bad_addr_width
    $error("serial_config_port: addr_width must be 6");
  end
  if (data_width != serial_config_pkg::data_width) begin : bad_data_width
    $error("serial_config_port: data_width must be 8");
  end
  if (serial_config_pkg::frame_bits != 2 + addr_width + data_width) begin : bad_frame_bits
    $error("serial_config_port: frame must hold direction, device, address and data");
  end
  if (serial_config_pkg::sync_stages != 3) begin : bad_sync_depth
    $error("serial_config_port: pin filter compares stages two and three");
  end

  // three-stage synchronisers; a change counts once stages two and three agree
  logic [2:0] sclk_sync;
  logic [2:0] sel_sync;
  logic [2:0] sdi_sync;
  logic sclk_level;
  logic sel_level;
  logic sdi_level;

  // pin order: 0 shift clock, 1 select, 2 serial in; one depth for all keeps data
  // aligned with the clock edge that samples it
  logic [2:0] pin_raw;
  assign pin_raw = {serial_in_line, select_active_low, shift_clock};

  for (genvar p = 0; p < 3; p++) begin : pin_sync
    // select idles high, the others low, so reset leaves no false edge behind
    localparam logic idle_level = (p == 1);
    logic [serial_config_pkg::sync_stages-1:0] stages;
    logic level;

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        stages <= {serial_config_pkg::sync_stages{idle_level}};
      end else if (clk_en) begin
        stages <= {stages[serial_config_pkg::sync_stages-2:0], pin_raw[p]};
      end
    end

    // filtered level: holds until the last two stages agree on a new value
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        level <= idle_level;
      end else if (clk_en && stages[1] == stages[2]) begin
        level <= stages[2];
      end
    end
  end

  assign sclk_sync = pin_sync[0].stages;
  assign sel_sync = pin_sync[1].stages;
  assign sdi_sync = pin_sync[2].stages;
  assign sclk_level = pin_sync[0].level;
  assign sel_level = pin_sync[1].level;
  assign sdi_level = pin_sync[2].level;

  // data follows the clock through the same pipeline, so the sampled bit
  // is the one present at the shift-clock rising edge
  logic sclk_rise;
  logic sel_fall;
  logic sel_rise;
  logic selected;
  assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_level;
  assign sel_fall = (sel_sync[1] == sel_sync[2]) && !sel_sync[2] && sel_level;
  assign sel_rise = (sel_sync[1] == sel_sync[2]) && sel_sync[2] && !sel_level;
  assign selected = !sel_level;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_shift = 3'b010,
    st_commit = 3'b100
  } port_state_t;

  port_state_t state;
  logic [4:0] bit_count;
  logic [serial_config_pkg::frame_bits-1:0] shift_in;
  logic [data_width-1:0] shift_out;
  logic [data_width-1:0] staged;
  logic [addr_width-1:0] last_addr;
  logic [data_width-1:0] mem_rd_data;
  logic mem_wr_en;
  logic mem_rd_en;
  logic [serial_config_pkg::frame_bits-1:0] frame;
  logic frame_full;
  logic frame_is_write;

  assign frame = shift_in;
  assign frame_full = (bit_count == 5'(serial_config_pkg::frame_bits));
  assign frame_is_write = frame_full
    && frame[serial_config_pkg::pos_direction] == serial_config_pkg::dir_write
    && frame[serial_config_pkg::pos_device] == serial_config_pkg::device_address;

  // frame sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= st_idle;
    end else if (clk_en) begin
      case (state)
        st_idle: begin
          if (sel_fall) begin
            state <= st_shift;
          end
        end
        st_shift: begin
          if (sel_rise) begin
            state <= st_commit;
          end
        end
        st_commit: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // input shift register, msb first; extra bits beyond sixteen are ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_in <= '0;
      bit_count <= 5'h00;
    end else if (clk_en) begin
      if (sel_fall) begin
        bit_count <= 5'h00;
      end else if (selected && sclk_rise && !frame_full) begin
        shift_in <= {shift_in[serial_config_pkg::frame_bits-2:0], sdi_level};
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // remember the address of the last complete command for this device, read or write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_addr <= '0;
    end else if (clk_en && state == st_shift && sel_rise && frame_full
                 && frame[serial_config_pkg::pos_device] == serial_config_pkg::device_address) begin
      last_addr <= frame[serial_config_pkg::pos_addr_hi:serial_config_pkg::pos_addr_lo];
    end
  end

  // the write lands on select rising; a read stores nothing
  assign mem_wr_en = (state == st_shift) && sel_rise && frame_is_write;
  // staged read happens the cycle after, so a write's new value is what is staged
  assign mem_rd_en = (state == st_commit);

  config_reg_mem #(
    .addr_width(addr_width),
    .data_width(data_width)
  ) regs (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr_en(mem_wr_en),
    .wr_addr(frame[serial_config_pkg::pos_addr_hi:serial_config_pkg::pos_addr_lo]),
    .wr_data(frame[data_width-1:0]),
    .rd_en(mem_rd_en),
    .rd_addr(last_addr),
    .rd_data(mem_rd_data)
  );

  // staged is reloaded in st_idle and held during a frame; mem output is valid from st_idle onward
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      staged <= serial_config_pkg::reset_value;
    end else if (clk_en && state == st_idle && !sel_fall) begin
      staged <= mem_rd_data;
    end
  end

  // output shifter: first bit appears at select fall, advances on rising edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_out <= '0;
    end else if (clk_en) begin
      if (sel_fall) begin
        shift_out <= staged;
      end else if (selected && sclk_rise) begin
        shift_out <= {shift_out[data_width-2:0], 1'b0};
      end
    end
  end

  // drive only for the first eight clocks, release while deselected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_line <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        serial_out_line <= staged[data_width-1];
        serial_out_oe <= 1'b1;
      end else if (!selected || (sclk_rise && bit_count == 5'(serial_config_pkg::out_bits - 1))) begin
        serial_out_oe <= 1'b0;
        serial_out_line <= 1'b0;
      end else if (sclk_rise && serial_out_oe) begin
        serial_out_line <= shift_out[data_width-2];
      end
    end
  end

  // live copies of the control registers that steer the analog blocks
  logic [data_width-1:0] pd_reg;
  logic [data_width-1:0] amp_trim_reg;
  logic [data_width-1:0] conv_trim_reg;

  logic [addr_width-1:0] frame_addr;
  assign frame_addr = frame[serial_config_pkg::pos_addr_hi:serial_config_pkg::pos_addr_lo];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_reg <= serial_config_pkg::reset_value;
    end else if (clk_en && mem_wr_en && frame_addr == serial_config_pkg::addr_power_down_control) begin
      pd_reg <= frame[data_width-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_trim_reg <= serial_config_pkg::reset_value;
    end else if (clk_en && mem_wr_en && frame_addr == serial_config_pkg::addr_amplifier_bias_trim) begin
      amp_trim_reg <= frame[data_width-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_trim_reg <= serial_config_pkg::reset_value;
    end else if (clk_en && mem_wr_en && frame_addr == serial_config_pkg::addr_converter_bias_trim) begin
      conv_trim_reg <= frame[data_width-1:0];
    end
  end

  // master powerdown forces every block off, else each bit acts alone
  logic master_pd;
  assign master_pd = pd_reg[serial_config_pkg::pd_master];

  // the clamp may be switched off alone when an external clamp is fitted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clamp_voltage_source_pd <= 1'b0;
    end else if (clk_en) begin
      clamp_voltage_source_pd <= master_pd | pd_reg[serial_config_pkg::pd_clamp];
    end
  end

  // per-channel groups allow single-channel operation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch1_refbuf_pd <= 1'b0;
      ch1_gain_amplifier_pd <= 1'b0;
      ch1_converter_pd <= 1'b0;
    end else if (clk_en) begin
      ch1_refbuf_pd <= master_pd | pd_reg[serial_config_pkg::pd_ch1_refbuf];
      ch1_gain_amplifier_pd <= master_pd | pd_reg[serial_config_pkg::pd_ch1_amp];
      ch1_converter_pd <= master_pd | pd_reg[serial_config_pkg::pd_ch1_conv];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch2_refbuf_pd <= 1'b0;
      ch2_gain_amplifier_pd <= 1'b0;
      ch2_converter_pd <= 1'b0;
    end else if (clk_en) begin
      ch2_refbuf_pd <= master_pd | pd_reg[serial_config_pkg::pd_ch2_refbuf];
      ch2_gain_amplifier_pd <= master_pd | pd_reg[serial_config_pkg::pd_ch2_amp];
      ch2_converter_pd <= master_pd | pd_reg[serial_config_pkg::pd_ch2_conv];
    end
  end

  // trims fan out to both channels alike
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_stage1_trim <= 3'h0;
      amp_stage2_trim <= 3'h0;
    end else if (clk_en) begin
      amp_stage1_trim <= amp_trim_reg[serial_config_pkg::trim_stage1_lo +: serial_config_pkg::trim_field_width];
      amp_stage2_trim <= amp_trim_reg[serial_config_pkg::trim_stage2_lo +: serial_config_pkg::trim_field_width];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_level1_trim <= 3'h0;
      conv_level2_trim <= 3'h0;
    end else if (clk_en) begin
      conv_level1_trim <= conv_trim_reg[serial_config_pkg::trim_stage1_lo +: serial_config_pkg::trim_field_width];
      conv_level2_trim <= conv_trim_reg[serial_config_pkg::trim_stage2_lo +: serial_config_pkg::trim_field_width];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/serial_master.sv ----
`default_nettype none
module serial_master (
  // serial port pins seen from the master
  output logic shift_clock,
  output logic select_active_low,
  output logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_out;
  logic out_wire;
  // a released line keeps no value, so show the inverse of the last one seen
  assign out_wire = serial_out_oe ? serial_out_line : ~last_out;
  initial begin
    shift_clock = 1'b0;
    select_active_low = 1'b1;
    serial_in_line = 1'b0;
    last_out = 1'b0;
  end
  // 400 ns shift period stays well below the 20 MHz main clock
  task automatic xfer(input logic [15:0] cmd, input int n, output logic [7:0] rd);
    rd = 8'h00;
    select_active_low = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      serial_in_line = cmd[15-i];
      #200;
      if (i < 8) begin
        rd[7-i] = out_wire;
        last_out = out_wire;
      end
      shift_clock = 1'b1;
      #200;
      shift_clock = 1'b0;
    end
    #200;
    select_active_low = 1'b1;
    serial_in_line = ~serial_in_line;
    #600;
  endtask
endmodule
`default_nettype wire

// ---- testbench/serial_config_port_sva.sv ----
`default_nettype none
module serial_config_port_sva (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // serial port pins
  input wire logic shift_clock,
  input wire logic select_active_low,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  // controls
  input wire logic clamp_voltage_source_pd,
  input wire logic ch1_converter_pd,
  input wire logic ch2_gain_amplifier_pd,
  input wire logic [2:0] amp_stage1_trim,
  input wire logic [2:0] conv_level2_trim
);
  logic sclk_q;
  logic [4:0] rise_cnt;
  logic [3:0] since_rise;
  // counts raw pin edges, so it leads the design's synchronised view
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      rise_cnt <= 5'h00;
      since_rise <= 4'hf;
    end else begin
      sclk_q <= shift_clock;
      if (select_active_low) rise_cnt <= 5'h00;
      else if (shift_clock && !sclk_q && rise_cnt != 5'h1f) rise_cnt <= rise_cnt + 5'h01;
      if (shift_clock && !sclk_q) since_rise <= 4'h0;
      else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  // a frozen design answers nothing, so attempts that meet a freeze are void
  default disable iff (!resetn || !clk_en);
  sequence s_idle; select_active_low [*6]; endsequence
  sequence s_busy; !select_active_low [*8]; endsequence
  sequence s_start; $fell(select_active_low) ##1 !select_active_low [*3]; endsequence
  sequence s_eighth; (rise_cnt == 5'h07) ##1 (rise_cnt == 5'h08); endsequence
  property p_release; s_idle |-> !serial_out_oe; endproperty
  property p_idle_low; !serial_out_oe |-> !serial_out_line; endproperty
  property p_start; s_start |-> ##[0:4] serial_out_oe; endproperty
  property p_stop; s_eighth |-> ##[1:6] !serial_out_oe; endproperty
  property p_stop_hold; rise_cnt > 5'h09 |-> !serial_out_oe; endproperty
  property p_shift; serial_out_oe && $past(serial_out_oe) && $changed(serial_out_line) |-> since_rise inside {[1:7]};
  endproperty
  property p_busy; s_busy |-> $stable({clamp_voltage_source_pd, ch1_converter_pd, amp_stage1_trim}); endproperty
  property p_commit;
    $changed({clamp_voltage_source_pd, ch2_gain_amplifier_pd, conv_level2_trim}) |-> $past(select_active_low, 3);
  endproperty
  a_release: assert property (p_release) else $error("output enabled while deselected");
  a_idle_low: assert property (p_idle_low) else $error("line not low while released");
  a_start: assert property (p_start) else $error("output not enabled after select fell");
  a_stop: assert property (p_stop) else $error("output still enabled after eighth clock");
  a_stop_hold: assert property (p_stop_hold) else $error("output enabled late in frame");
  a_shift: assert property (p_shift) else $error("output changed away from a shift edge");
  a_busy: assert property (p_busy) else $error("control changed inside a frame");
  a_commit: assert property (p_commit) else $error("control changed before select rose");
endmodule
bind serial_config_port serial_config_port_sva chk (.clk(clk), .resetn(resetn), .clk_en(clk_en), .shift_clock(shift_clock),
  .select_active_low(select_active_low), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
  .clamp_voltage_source_pd(clamp_voltage_source_pd), .ch1_converter_pd(ch1_converter_pd),
  .ch2_gain_amplifier_pd(ch2_gain_amplifier_pd), .amp_stage1_trim(amp_stage1_trim),
  .conv_level2_trim(conv_level2_trim));
`default_nettype wire

// ---- testbench/serial_config_port_test.sv ----
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module serial_config_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] frozen_rd;
  logic shift_clock, select_active_low, serial_in_line, serial_out_line, serial_out_oe;
  logic clamp_pd, ch1_ref_pd, ch2_ref_pd, ch1_amp_pd, ch2_amp_pd, ch1_conv_pd, ch2_conv_pd;
  logic [2:0] amp1, amp2, conv1, conv2;
  logic [6:0] pd_vec;
  logic [20:0] all_out;
  logic [7:0] exp_mem [64];
  logic [5:0] last_addr;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  assign pd_vec = {clamp_pd, ch2_ref_pd, ch1_ref_pd, ch2_amp_pd, ch1_amp_pd, ch2_conv_pd, ch1_conv_pd};
  assign all_out = {pd_vec, amp2, amp1, conv2, conv1, serial_out_line, serial_out_oe};
  // main clock never stops, even across frames
  initial forever #25 clk = ~clk;
  serial_master m (.shift_clock(shift_clock), .select_active_low(select_active_low),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe));
  serial_config_port dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .shift_clock(shift_clock),
    .select_active_low(select_active_low), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe), .clamp_voltage_source_pd(clamp_pd), .ch1_refbuf_pd(ch1_ref_pd),
    .ch2_refbuf_pd(ch2_ref_pd), .ch1_gain_amplifier_pd(ch1_amp_pd), .ch2_gain_amplifier_pd(ch2_amp_pd),
    .ch1_converter_pd(ch1_conv_pd), .ch2_converter_pd(ch2_conv_pd), .amp_stage1_trim(amp1),
    .amp_stage2_trim(amp2), .conv_level1_trim(conv1), .conv_level2_trim(conv2));
  task automatic end_sim();
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // called at time zero or at a falling edge; reset then spans two rising edges
  task automatic do_reset();
    resetn = 1'b0;
    for (int i = 0; i < 64; i++) exp_mem[i] = serial_config_pkg::reset_value;
    last_addr = 6'h00;
    repeat (2) @(negedge clk);
    `CHK(all_out, 21'h0)
    resetn = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // one frame: returned byte and all controls are compared with the model
  task automatic op(input logic [15:0] cmd, input int n);
    logic [7:0] rd;
    logic [7:0] pd_reg;
    @(negedge clk);
    m.xfer(cmd, n, rd);
    `CHK(rd, exp_mem[last_addr])
    if (n >= 16 && cmd[14] == serial_config_pkg::device_address) begin
      last_addr = cmd[13:8];
      if (cmd[15] == serial_config_pkg::dir_write) exp_mem[last_addr] = cmd[7:0];
    end
    pd_reg = exp_mem[serial_config_pkg::addr_power_down_control];
    `CHK(pd_vec, pd_reg[7] ? 7'h7f : pd_reg[6:0])
    `CHK({amp2, amp1, conv2, conv1}, {exp_mem[2][5:0], exp_mem[3][5:0]})
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    do_reset();
    for (int i = 63; i >= 0; i--) op({2'b00, 6'(i), 8'(i * 7 + 3)}, 16);
    op(16'h0100, 16);
    op(16'h0224, 16);
    op(16'h035b, 16);
    for (int i = 0; i < 7; i++) op({8'h01, 8'h01 << i}, 16);
    op(16'h0181, 16);
    op(16'h0209, 16);
    op(16'h0308, 16);
    op(16'h8200, 16);
    op(16'h3f5a, 16);
    op(16'hbf00, 16);
    op(16'h0180, 16);
    op(16'h42ff, 16);
    op(16'h02ff, 8);
    // a frame sent while the design is frozen must leave every register untouched
    clk_en = 1'b0;
    m.xfer(16'h0100, 16, frozen_rd);
    clk_en = 1'b1;
    op(16'h8100, 16);
    do_reset();
    op(16'h0224, 16);
    end_sim();
  end
endmodule
`default_nettype wire
